// [rtl/dlc_defines.svh]
// Register offsets, field positions and timing counts for the DLL/clock-change block.
// Included by the design, the controller model and the bench; holds macros only.
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH

`define DLC_REG_STATUS 4'h0
`define DLC_REG_CTRL 4'h4

`define DLC_ST_DLL_ON 0
`define DLC_ST_LOCKED 1
`define DLC_ST_SREF 2
`define DLC_ST_PDN 3
`define DLC_ST_CLK_IGN 4
`define DLC_ST_READY 5
`define DLC_ST_LAT_OK 6
`define DLC_ST_ERR_EARLY 8
`define DLC_ST_ERR_CLK 9
`define DLC_CTRL_LAT_CHK 0

// Mode register fields on the address pins
`define DLC_MR1_DLL_DIS 0
`define DLC_MR0_DLL_RST 8
`define DLC_CL6_CODE 4'h4
`define DLC_CWL6_CODE 3'h1

// Command codes {cs_b, ras_b, cas_b, we_b}
`define DLC_CMD_MRS 4'h0
`define DLC_CMD_REF 4'h1
`define DLC_CMD_ZQ 4'h6
`define DLC_CMD_NOP 4'h7

// Timing in link clock cycles (nCK); DLC_PER_TOL is in system clock cycles
`define DLC_T_MRD 4
`define DLC_T_MOD 12
`define DLC_T_XS 64
`define DLC_T_XP 4
`define DLC_T_DLLK 512
`define DLC_T_CKSRE 5
`define DLC_T_CKSRX 5
`define DLC_PER_TOL 8'h01

`endif

// [rtl/dlc_dll_clock_change.sv]
// DRAM-side DLL on/off and input clock rate change tracking.
// Assumes link pins arrive asynchronously; the memory clock is sampled, not used as a clock.
// Operation
// - MR1 A0 high disables DLL until written low; tMOD before self-refresh (self-refresh entry is not checked against tMOD here).
// - After last DLL-off mode write, next command accepted after tMOD.
// - After tXS, MR1 A0 written low re-enables the DLL.
// - After tMRD, MR0 A8 high starts a DLL reset.
// - In self-refresh past tCKSRE the device ignores the clock.
// - During re-lock ODT low, CKE high; after lock runs at new rate. ODT is synchronised but never used here.
// - DLL-off mode needs only CAS latency 6 with write latency 6.
`timescale 1ns/1ps
`include "dlc_defines.svh"

module dlc_dll_clock_change #(
  parameter int T_MRD = `DLC_T_MRD,
  parameter int T_MOD = `DLC_T_MOD,
  parameter int T_XS = `DLC_T_XS,
  parameter int T_XP = `DLC_T_XP,
  parameter int T_DLLK = `DLC_T_DLLK,
  parameter int T_CKSRE = `DLC_T_CKSRE,
  parameter int T_CKSRX = `DLC_T_CKSRX
) (
  // System
  input wire logic clock,
  input wire logic rst_b,
  // Memory link pins
  input wire logic mem_ck,
  input wire logic mem_cke,
  input wire logic mem_odt,
  input wire logic mem_cs_b,
  input wire logic mem_ras_b,
  input wire logic mem_cas_b,
  input wire logic mem_we_b,
  input wire logic [2:0] mem_ba,
  input wire logic [13:0] mem_addr,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Status
  output logic dll_on,
  output logic dll_locked,
  output logic self_refresh,
  output logic power_down,
  output logic clk_ignored,
  output logic cmd_ready
);
  localparam int PW = 24;
  localparam int CW = 10;

  function automatic logic cmd_is(input logic [3:0] c, input logic [3:0] p);
    return c == p;
  endfunction

  // Two-flop synchronisers for every pin
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic ck_prev;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
      ck_prev <= 1'b0;
    end else begin
      pin_meta <= {mem_ck, mem_cke, mem_odt, mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b,
                   mem_ba, mem_addr};
      pin_sync <= pin_meta;
      ck_prev <= pin_sync[23];
    end
  end

  logic ck_rise;
  logic s_cke;
  logic [3:0] s_cmd;
  logic [2:0] s_ba;
  logic [13:0] s_addr;
  assign ck_rise = pin_sync[23] && !ck_prev;
  assign s_cke = pin_sync[22];
  assign s_cmd = pin_sync[20:17];
  assign s_ba = pin_sync[16:14];
  assign s_addr = pin_sync[13:0];

  logic cke_prev;
  logic cmd_live;
  logic is_mrs;
  logic is_ref;
  assign cmd_live = ck_rise && cke_prev && s_cke;
  assign is_mrs = cmd_live && cmd_is(s_cmd, `DLC_CMD_MRS);
  assign is_ref = ck_rise && cke_prev && !s_cke && cmd_is(s_cmd, `DLC_CMD_REF);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) cke_prev <= 1'b0;
    else if (ck_rise) cke_prev <= s_cke;
  end

  // Power state
  dlc_pkg::dlc_state_t state;
  logic exit_now;
  assign exit_now = ck_rise && !cke_prev && s_cke && (state != dlc_pkg::DLC_IDLE);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= dlc_pkg::DLC_IDLE;
    end else if (ck_rise) begin
      case (state)
        dlc_pkg::DLC_IDLE: begin
          if (is_ref) state <= dlc_pkg::DLC_SREF;
          else if (cke_prev && !s_cke) state <= dlc_pkg::DLC_PDN;
        end
        dlc_pkg::DLC_SREF, dlc_pkg::DLC_PDN: begin
          if (s_cke) state <= dlc_pkg::DLC_IDLE;
        end
        default: state <= dlc_pkg::DLC_IDLE;
      endcase
    end
  end

  // Edges since entry; past tCKSRE the clock may change
  logic [CW-1:0] sre_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sre_cnt <= '0;
    else if (state == dlc_pkg::DLC_IDLE) sre_cnt <= '0;
    else if (ck_rise && sre_cnt != CW'(T_CKSRE)) sre_cnt <= sre_cnt + 1'b1;
  end

  // Period monitor: count edges with an unchanged period before exit
  logic [7:0] per_cnt;
  logic [7:0] per_last;
  logic [CW-1:0] stable_cnt;
  logic per_match;
  assign per_match = (per_cnt - per_last <= `DLC_PER_TOL) || (per_last - per_cnt <= `DLC_PER_TOL);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt <= '0;
      per_last <= '0;
      stable_cnt <= '0;
    end else if (ck_rise) begin
      per_cnt <= 8'h01;
      per_last <= per_cnt;
      if (!per_match) stable_cnt <= '0;
      else if (stable_cnt != CW'(T_CKSRX)) stable_cnt <= stable_cnt + 1'b1;
    end else if (per_cnt != 8'hff) begin
      per_cnt <= per_cnt + 8'h01;
    end
  end

  // Busy timers: mode write spacing and exit recovery
  logic [CW-1:0] mod_cnt;
  logic [CW-1:0] mrd_cnt;
  logic [CW-1:0] xs_cnt;
  // mode writes need only tMRD between them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mrd_cnt <= '0;
    else if (is_mrs) mrd_cnt <= CW'(T_MRD);
    else if (ck_rise && mrd_cnt != '0) mrd_cnt <= mrd_cnt - 1'b1;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mod_cnt <= '0;
    else if (is_mrs) mod_cnt <= CW'(T_MOD);
    else if (ck_rise && mod_cnt != '0) mod_cnt <= mod_cnt - 1'b1;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) xs_cnt <= '0;
    else if (exit_now) xs_cnt <= (state == dlc_pkg::DLC_SREF) ? CW'(T_XS) : CW'(T_XP);
    else if (ck_rise && xs_cnt != '0) xs_cnt <= xs_cnt - 1'b1;
  end

  // Mode bits held by the device
  logic [3:0] cl_code;
  logic [2:0] cwl_code;
  logic [CW-1:0] dllk_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dll_on <= 1'b1;
    else if (is_mrs && s_ba == 3'h1) dll_on <= !s_addr[`DLC_MR1_DLL_DIS];
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cl_code <= `DLC_CL6_CODE;
      cwl_code <= `DLC_CWL6_CODE;
    end else if (is_mrs && s_ba == 3'h0) begin
      cl_code <= {s_addr[6:4], s_addr[2]};
    end else if (is_mrs && s_ba == 3'h2) begin
      cwl_code <= s_addr[5:3];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dllk_cnt <= '0;
    else if (is_mrs && s_ba == 3'h0 && s_addr[`DLC_MR0_DLL_RST]) dllk_cnt <= CW'(T_DLLK);
    else if (ck_rise && dllk_cnt != '0) dllk_cnt <= dllk_cnt - 1'b1;
  end
  // Relock only completes with the DLL enabled; disabling drops lock at once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dll_locked <= 1'b0;
    else if (!dll_on || (is_mrs && s_ba == 3'h1)) dll_locked <= 1'b0;
    else if (is_mrs && s_ba == 3'h0 && s_addr[`DLC_MR0_DLL_RST]) dll_locked <= 1'b0;
    else if (ck_rise && dllk_cnt == CW'(1)) dll_locked <= 1'b1;
  end

  // Status outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      self_refresh <= 1'b0;
      power_down <= 1'b0;
      clk_ignored <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      self_refresh <= state == dlc_pkg::DLC_SREF;
      power_down <= state == dlc_pkg::DLC_PDN;
      clk_ignored <= state == dlc_pkg::DLC_SREF && sre_cnt == CW'(T_CKSRE);
      cmd_ready <= state == dlc_pkg::DLC_IDLE && mod_cnt == '0 && xs_cnt == '0 && !is_mrs;
    end
  end

  // Latency check for DLL-off mode
  logic lat_chk;
  logic lat_ok;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) lat_ok <= 1'b1;
    else lat_ok <= dll_on || !lat_chk || (cl_code == `DLC_CL6_CODE && cwl_code == `DLC_CWL6_CODE);
  end

  // Sticky errors; a new event wins over a software clear
  logic err_early;
  logic err_clk;
  logic clr_wr;
  logic early_ev;
  logic clk_ev;
  assign clr_wr = reg_wr && reg_addr == `DLC_REG_STATUS;
  // Mode writes are spaced by tMRD, any other CKE-high command except NOP or deselect by tMOD
  assign early_ev = cmd_live && !cmd_is(s_cmd, `DLC_CMD_NOP) && s_cmd[3] == 1'b0 &&
                    (xs_cnt != '0 ||
                     (cmd_is(s_cmd, `DLC_CMD_MRS) ? mrd_cnt != '0 : mod_cnt != '0));
  assign clk_ev = exit_now && sre_cnt == CW'(T_CKSRE) && stable_cnt != CW'(T_CKSRX);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) err_early <= 1'b0;
    else if (early_ev) err_early <= 1'b1;
    else if (clr_wr && reg_wdata[`DLC_ST_ERR_EARLY]) err_early <= 1'b0;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) err_clk <= 1'b0;
    else if (clk_ev) err_clk <= 1'b1;
    else if (clr_wr && reg_wdata[`DLC_ST_ERR_CLK]) err_clk <= 1'b0;
  end

  // Register port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) lat_chk <= 1'b1;
    else if (reg_wr && reg_addr == `DLC_REG_CTRL) lat_chk <= reg_wdata[`DLC_CTRL_LAT_CHK];
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `DLC_REG_STATUS: reg_rdata <= {6'h00, err_clk, err_early, 1'b0, lat_ok, cmd_ready,
                                       clk_ignored, power_down, self_refresh, dll_locked, dll_on};
        `DLC_REG_CTRL: reg_rdata <= {15'h0000, lat_chk};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_dll_reset;
    is_mrs && s_ba == 3'h0 && s_addr[`DLC_MR0_DLL_RST] && dll_on;
  endsequence
  sequence s_lock_pending;
    !dll_locked [*3];
  endsequence

  property p_dll_off;
    is_mrs && s_ba == 3'h1 && s_addr[`DLC_MR1_DLL_DIS] |=> !dll_on && !dll_locked;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("DLL not disabled by mode write");
  property p_dll_on;
    is_mrs && s_ba == 3'h1 && !s_addr[`DLC_MR1_DLL_DIS] |=> dll_on;
  endproperty
  a_dll_on: assert property (p_dll_on) else $error("DLL not enabled by mode write");
  property p_reset_drops;
    s_dll_reset |=> s_lock_pending;
  endproperty
  a_reset_drops: assert property (p_reset_drops) else $error("Lock kept across DLL reset");
  property p_lock_time;
    $rose(dll_locked) |-> $past(dllk_cnt) == CW'(1) && dll_on;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("Lock not at end of lock time");
  property p_mod_busy;
    is_mrs |=> !cmd_ready [*2];
  endproperty
  a_mod_busy: assert property (p_mod_busy) else $error("Ready too soon after mode write");
  property p_ignore;
    clk_ignored |-> self_refresh && sre_cnt == CW'(T_CKSRE);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Clock ignored outside self-refresh");
  property p_sref_entry;
    is_ref && state == dlc_pkg::DLC_IDLE |=> ##1 self_refresh;
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("Self-refresh not entered");
  property p_latency;
    !dll_on && lat_chk && cl_code != `DLC_CL6_CODE |=> !lat_ok;
  endproperty
  a_latency: assert property (p_latency) else $error("Bad DLL-off latency accepted");
endmodule

// [rtl/dlc_pkg.sv]
// Types shared by the DLL/clock-change block.
// Constants live in dlc_defines.svh.
package dlc_pkg;
  typedef enum logic [1:0] {DLC_IDLE, DLC_SREF, DLC_PDN} dlc_state_t;
endpackage

// [tb/dlc_ctl_model.sv]
// Memory controller model driving the link pins of the DLL/clock-change block.
// Assumes the bench calls one task at a time; the memory clock runs free.
`timescale 1ns/1ps
`include "dlc_defines.svh"

module dlc_ctl_model #(
  parameter int T_CKSRE = `DLC_T_CKSRE,
  parameter int T_CKSRX = `DLC_T_CKSRX
) (
  // Link pins
  output logic mem_ck,
  output logic mem_cke,
  output logic mem_odt,
  output logic mem_cs_b,
  output logic mem_ras_b,
  output logic mem_cas_b,
  output logic mem_we_b,
  output logic [2:0] mem_ba,
  output logic [13:0] mem_addr
);
  int half = 80;
  logic [3:0] code = 4'hf;

  assign {mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b} = code;
  initial begin
    mem_ck = 1'b0;
    mem_cke = 1'b1;
    mem_odt = 1'b0;
    mem_ba = 3'h0;
    mem_addr = 14'h0;
  end
  always #(half) mem_ck = ~mem_ck;

  task automatic ticks(input int n);
    repeat (n) @(posedge mem_ck);
  endtask

  // Pins settle half a period before the rise; deselect scrambles the address
  task automatic cmd(input logic [3:0] k, input logic [2:0] b, input logic [13:0] a,
                     input logic cke);
    @(negedge mem_ck);
    code = k;
    mem_ba = b;
    mem_addr = a;
    mem_cke = cke;
    @(negedge mem_ck);
    code = 4'hf;
    mem_ba = ~b;
    mem_addr = ~a;
  endtask

  // Only called in self-refresh or power-down
  task automatic set_rate(input int h);
    @(negedge mem_ck);
    half = h;
  endtask

  // Enter low power, wait tCKSRE, new rate, stable for the given edge count, exit
  task automatic low_power_change(input logic [3:0] k, input int h, input int stable);
    cmd(k, 3'h0, 14'h0, 1'b0);
    ticks(T_CKSRE + 1);
    set_rate(h);
    ticks(stable);
    // Exit with CKE high after the stable clock
    cmd(`DLC_CMD_NOP, 3'h0, 14'h0, 1'b1);
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the DLL/clock-change block.
// Assumes the controller model drives the link; the bench owns the register port.
`timescale 1ns/1ps
`include "dlc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  localparam int XS = 8;
  localparam int DLLK = 16;
  logic clock = 1'b0;
  logic rst_b;
  logic mem_ck, mem_cke, mem_odt, mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b;
  logic [2:0] mem_ba;
  logic [13:0] mem_addr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, s;
  logic reg_wr, reg_rd;
  logic dll_on, dll_locked, self_refresh, power_down, clk_ignored, cmd_ready;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  dlc_ctl_model u_ctl (.mem_ck(mem_ck), .mem_cke(mem_cke), .mem_odt(mem_odt),
    .mem_cs_b(mem_cs_b), .mem_ras_b(mem_ras_b), .mem_cas_b(mem_cas_b),
    .mem_we_b(mem_we_b), .mem_ba(mem_ba), .mem_addr(mem_addr));

  dlc_dll_clock_change #(.T_XS(XS), .T_DLLK(DLLK)) u_dut (.clock(clock), .rst_b(rst_b),
    .mem_ck(mem_ck), .mem_cke(mem_cke), .mem_odt(mem_odt), .mem_cs_b(mem_cs_b),
    .mem_ras_b(mem_ras_b), .mem_cas_b(mem_cas_b), .mem_we_b(mem_we_b), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dll_on(dll_on), .dll_locked(dll_locked),
    .self_refresh(self_refresh), .power_down(power_down), .clk_ignored(clk_ignored),
    .cmd_ready(cmd_ready));

  task automatic end_sim();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Pin sync plus decode latency
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask

  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    u_ctl.cmd(`DLC_CMD_MRS, b, a, 1'b1);
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK({dll_on, dll_locked, self_refresh, power_down, clk_ignored, cmd_ready}, 6'h21)
    rd(`DLC_REG_CTRL, s);
    `CHK(s, 16'h0001)
    wr(4'h8, 16'hffff);
    rd(4'h8, s);
    `CHK(s, 16'h0000)
    rd(`DLC_REG_CTRL, s);
    `CHK(s, 16'h0001)
    u_ctl.ticks(2);
    // DLL off, then tMOD busy
    mrs(3'h1, 14'h0001);
    settle();
    `CHK({dll_on, cmd_ready}, 2'b00)
    u_ctl.ticks(7);
    settle();
    `CHK(cmd_ready, 1'b0)
    u_ctl.ticks(6);
    settle();
    `CHK(cmd_ready, 1'b1)
    // Self-refresh entry, slower clock, exit
    u_ctl.cmd(`DLC_CMD_REF, 3'h0, 14'h0, 1'b0);
    settle();
    `CHK({self_refresh, clk_ignored}, 2'b10)
    u_ctl.ticks(`DLC_T_CKSRE + 1);
    settle();
    `CHK(clk_ignored, 1'b1)
    u_ctl.set_rate(120);
    // Two mixed periods follow a rate change before tCKSRX stable ones
    u_ctl.ticks(`DLC_T_CKSRX + 2);
    u_ctl.cmd(`DLC_CMD_NOP, 3'h0, 14'h0, 1'b1);
    settle();
    `CHK({self_refresh, clk_ignored, dll_on}, 3'b000)
    u_ctl.ticks(XS);
    // Wrong CL while DLL off, then CL6/CWL6
    mrs(3'h0, 14'h0000);
    u_ctl.ticks(13);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0040, 16'h0000)
    mrs(3'h0, 14'h0020);
    u_ctl.ticks(13);
    mrs(3'h2, 14'h0008);
    u_ctl.ticks(13);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0361, 16'h0060)
    // Mode write inside tMRD is flagged, write-one clears
    mrs(3'h0, 14'h0020);
    u_ctl.ticks(2);
    mrs(3'h0, 14'h0020);
    u_ctl.ticks(13);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0100, 16'h0100)
    wr(`DLC_REG_STATUS, 16'h0100);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0100, 16'h0000)
    // DLL back on through self-refresh
    u_ctl.low_power_change(`DLC_CMD_REF, 80, `DLC_T_CKSRX + 2);
    u_ctl.ticks(XS + 1);
    mrs(3'h1, 14'h0000);
    settle();
    `CHK({dll_on, dll_locked}, 2'b10)
    u_ctl.ticks(`DLC_T_MRD);
    mrs(3'h0, 14'h0120);
    u_ctl.ticks(8);
    settle();
    `CHK(dll_locked, 1'b0)
    u_ctl.ticks(10);
    settle();
    `CHK(dll_locked, 1'b1)
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0300, 16'h0000)
    // Exit with too few stable periods
    u_ctl.low_power_change(`DLC_CMD_REF, 100, 2);
    u_ctl.ticks(XS + 1);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0200, 16'h0200)
    wr(`DLC_REG_STATUS, 16'h0200);
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0200, 16'h0000)
    // Precharge power-down rate change
    u_ctl.cmd(`DLC_CMD_NOP, 3'h0, 14'h0, 1'b0);
    settle();
    `CHK({power_down, self_refresh}, 2'b10)
    u_ctl.ticks(`DLC_T_CKSRE + 1);
    u_ctl.set_rate(80);
    u_ctl.ticks(`DLC_T_CKSRX + 2);
    u_ctl.cmd(`DLC_CMD_NOP, 3'h0, 14'h0, 1'b1);
    settle();
    `CHK(power_down, 1'b0)
    u_ctl.ticks(`DLC_T_XP + 1);
    mrs(3'h0, 14'h0120);
    u_ctl.ticks(DLLK + 4);
    settle();
    `CHK({dll_on, dll_locked, cmd_ready}, 3'b111)
    rd(`DLC_REG_STATUS, s);
    `CHK(s & 16'h0300, 16'h0000)
    end_sim();
  end
endmodule
